// >>> src/eqt_tuning_fsm.sv
// Receive-equalizer tuning enable machine for one transceiver octal.
// Assumes user logic and the octal configuration port share clk_sys.
`timescale 1ns/1ps

module eqt_tuning_fsm
   import eqt_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         tuning_reset,
   // Octal receive status
   input  wire logic [7:0]   rx_path_ready,
   input  wire logic [7:0]   active_channels,
   // User control
   input  wire logic [3:0]   channel_select,
   input  wire logic         retune_req,
   input  wire logic [7:0]   near_loopback_en,
   // Completion and debug
   output      logic [7:0]   tuning_done,
   output      logic [8:0]   state_debug,
   output      logic [3:0]   status_channel_debug,
   // Configuration port master
   output      eqt_cfg_req_s config_port_req,
   input  wire logic [31:0]  config_port_rdata,
   input  wire logic         config_port_ready
);

   // ==========================================================================
   // Machine state
   eqt_state_e   state, next_state;
   logic [2:0]   chan, next_chan;
   logic         all_mode, next_all_mode;
   logic         phase, next_phase;        // 0: control write, 1: status read
   logic [7:0]   poll, next_poll;
   logic [7:0]   next_done;
   eqt_cfg_req_s next_req;
   logic [15:0]  rom_addr;
   logic         hold;

   // Stay parked while any active channel is not yet receiving
   assign hold = tuning_reset | (|(active_channels & ~rx_path_ready));

   // ==========================================================================
   // Address table
   eqt_addr_rom u_rom (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .is_status (phase),
      .chan      (chan),
      .addr      (rom_addr)
   );

   // Control word: both tuning loops on, loopback as the user holds it
   function automatic logic [31:0] ctrl_word(input logic loop_en);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CTRL_COARSE_BIT] = 1'b1;
      w[CTRL_FINE_BIT]   = 1'b1;
      w[CTRL_LOOP_BIT]   = loop_en;
      return w;
   endfunction

   // ==========================================================================
   // Next-state logic
   always_comb begin
      next_state    = state;
      next_chan     = chan;
      next_all_mode = all_mode;
      next_phase    = phase;
      next_poll     = poll;
      next_done     = tuning_done;
      next_req      = config_port_req;
      next_req.en   = 1'b0;
      case (state)
         ST_HOLD: begin
            // Fresh start always walks every channel
            next_chan     = 3'h0;
            next_all_mode = 1'b1;
            next_phase    = 1'b0;
            next_poll     = 8'h00;
            next_state    = ST_ADDR;
         end
         ST_ADDR: begin
            // Table read takes a cycle
            next_state = ST_ISSUE;
         end
         ST_ISSUE: begin
            next_req.en    = 1'b1;
            next_req.we    = ~phase;
            next_req.addr  = rom_addr;
            next_req.wdata = phase ? 32'h0000_0000 : ctrl_word(near_loopback_en[chan]);
            next_state     = ST_WAIT;
         end
         ST_WAIT: begin
            // Ignore ready in the enable cycle itself
            if (config_port_ready && !config_port_req.en) begin
               if (!phase) begin
                  next_phase = 1'b1;
                  next_poll  = 8'h00;
                  next_state = ST_ADDR;
               end else if (config_port_rdata[STAT_DONE_BIT]) begin
                  next_done[chan] = ~config_port_rdata[STAT_ERR_BIT];
                  next_state      = ST_NEXT;
               end else if (poll == POLL_MAX) begin
                  // A stuck channel must not block the rest of the octal
                  next_done[chan] = 1'b0;
                  next_state      = ST_NEXT;
               end else begin
                  next_poll  = 8'(poll + 8'h01);
                  next_state = ST_ADDR;
               end
            end
         end
         ST_NEXT: begin
            if (all_mode && chan != CHAN_LAST) begin
               next_chan  = 3'(chan + 3'h1);
               next_phase = 1'b0;
               next_state = ST_ADDR;
            end else begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // Park here; only a legal retune request or a hold leaves
            if (retune_req) begin
               if (channel_select < CHAN_ALL) begin
                  next_chan       = channel_select[2:0];
                  next_all_mode   = 1'b0;
                  next_phase      = 1'b0;
                  next_done[channel_select[2:0]] = 1'b0;
                  next_state      = ST_ADDR;
               end else if (channel_select == CHAN_ALL) begin
                  next_chan     = 3'h0;
                  next_all_mode = 1'b1;
                  next_phase    = 1'b0;
                  next_done     = FLAGS_RESET;
                  next_state    = ST_ADDR;
               end
            end
         end
         default: begin
            next_state = ST_HOLD;
         end
      endcase
      // Reset of the tuner overrides state, flags and request, select is disregarded
      if (hold) begin
         next_state  = ST_HOLD;
         next_done   = FLAGS_RESET;
         next_req    = REQ_IDLE;
      end
   end

   // ==========================================================================
   // State registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state           <= ST_HOLD;
         chan            <= 3'h0;
         all_mode        <= 1'b1;
         phase           <= 1'b0;
         poll            <= 8'h00;
         tuning_done     <= FLAGS_RESET;
         config_port_req <= REQ_IDLE;
      end else begin
         state           <= next_state;
         chan            <= next_chan;
         all_mode        <= next_all_mode;
         phase           <= next_phase;
         poll            <= next_poll;
         tuning_done     <= next_done;
         config_port_req <= next_req;
      end
   end

   // ==========================================================================
   // Debug outputs: one-hot state and channel being examined
   assign state_debug          = 9'(9'h001 << state);
   assign status_channel_debug = {1'b0, chan};

endmodule

// >>> include/eqt_pkg.sv
// Shared constants and types of the receive-equalizer tuning enable machine.
// Assumes the configuration port of one transceiver octal with 32-bit data.
package eqt_pkg;

   // ==========================================================================
   // Widths and channel selection
   localparam int          NUM_CHAN      = 8;
   localparam logic [3:0]  CHAN_ALL      = 4'h8;
   localparam logic [2:0]  CHAN_LAST     = 3'h7;

   // ==========================================================================
   // Configuration-port map (plain defaults, not from any real part)
   localparam logic [15:0] CTRL_BASE     = 16'h0100;
   localparam logic [15:0] STAT_BASE     = 16'h0104;
   localparam logic [15:0] CHAN_STRIDE   = 16'h0040;

   // ==========================================================================
   // Field positions of the control word and the status word
   localparam int          CTRL_COARSE_BIT = 0;
   localparam int          CTRL_FINE_BIT   = 1;
   localparam int          CTRL_LOOP_BIT   = 2;
   localparam int          STAT_DONE_BIT   = 0;
   localparam int          STAT_ERR_BIT    = 1;

   // ==========================================================================
   // Reset values and poll limit
   localparam logic [7:0]  FLAGS_RESET   = 8'h00;
   localparam logic [7:0]  POLL_MAX      = 8'hFF;

   // ==========================================================================
   // Types
   typedef struct packed {
      logic        en;
      logic        we;
      logic [15:0] addr;
      logic [31:0] wdata;
   } eqt_cfg_req_s;

   localparam eqt_cfg_req_s REQ_IDLE = '{en: 1'b0, we: 1'b0, addr: 16'h0000, wdata: 32'h0000_0000};

   typedef enum logic [2:0] {
      ST_HOLD,
      ST_ADDR,
      ST_ISSUE,
      ST_WAIT,
      ST_NEXT,
      ST_DONE
   } eqt_state_e;

endpackage

// >>> src/eqt_addr_rom.sv
// Address table: control and status word address for each of the eight channels.
// Assumes a read one cycle before use; the address comes out of a register.
`timescale 1ns/1ps

module eqt_addr_rom
   import eqt_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Lookup
   input  wire logic        is_status,
   input  wire logic [2:0]  chan,
   output      logic [15:0] addr
);

   // ==========================================================================
   // Table contents
   logic [15:0] table_q [0:2*NUM_CHAN-1];

   // One control and one status word per channel, spaced by the stride
   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++) begin : gen_entry
         assign table_q[2*g]   = 16'(CTRL_BASE + 16'(g) * CHAN_STRIDE);
         assign table_q[2*g+1] = 16'(STAT_BASE + 16'(g) * CHAN_STRIDE);
      end
   endgenerate

   // ==========================================================================
   // Registered read port
   logic [15:0] next_addr;

   always_comb begin
      next_addr = table_q[{chan, is_status}];
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         addr <= 16'h0000;
      end else begin
         addr <= next_addr;
      end
   end

endmodule

// >>> tb/eqt_port_model.sv
// Behavioural octal configuration port answering the tuner's accesses.
// Assumes one access outstanding at a time, all on clk_sys.
`timescale 1ns/1ps
// =====
// Port model
module eqt_port_model
   import eqt_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // Test controls
   input  wire logic         slow,
   input  wire logic         err,
   input  wire logic [3:0]   need,
   // Port
   input  wire eqt_cfg_req_s req,
   output      logic [31:0]  rdata,
   output      logic         ready
);
   logic [3:0] cnt;
   logic [3:0] polls;
   logic       wr;
   // One ready pulse per access; data churns when not answering
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt   <= 4'h0;
         polls <= 4'h0;
         wr    <= 1'b0;
         ready <= 1'b0;
         rdata <= 32'h0;
      end else begin
         ready <= 1'b0;
         rdata <= ~rdata;
         if (req.en) begin
            cnt <= slow ? 4'h5 : 4'h1;
            wr  <= req.we;
            if (req.we) polls <= 4'h0;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
               ready <= 1'b1;
               rdata <= {30'h0, err, (polls + 4'h1 >= need)};
               if (!wr) polls <= polls + 4'h1;
            end
         end
      end
   end
endmodule

// >>> tb/eqt_checker.sv
// Concurrent checks on the tuner's ports.
// Assumes one clock domain, bound to every tuner instance.
`timescale 1ns/1ps
// =====
// Checker
module eqt_checker
   import eqt_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         tuning_reset,
   input  wire logic [7:0]   rx_path_ready,
   input  wire logic [7:0]   active_channels,
   input  wire logic [3:0]   channel_select,
   input  wire logic         retune_req,
   input  wire logic [7:0]   near_loopback_en,
   input  wire logic [7:0]   tuning_done,
   input  wire logic [8:0]   state_debug,
   input  wire logic [3:0]   status_channel_debug,
   input  wire eqt_cfg_req_s config_port_req,
   input  wire logic [31:0]  config_port_rdata,
   input  wire logic         config_port_ready
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic ok;
   logic busy;
   assign ok = ((rx_path_ready & active_channels) == active_channels) && !tuning_reset;
   // Access outstanding; an abandoned one is dropped on hold
   always_ff @(posedge clk_sys or posedge rst)
      if (rst) busy <= 1'b0;
      else busy <= (config_port_req.en || (busy && !config_port_ready)) && !state_debug[0];
   a_en_pulse: assert property (config_port_req.en |=> !config_port_req.en)
      else $error("enable longer than one cycle");
   a_wait_ready: assert property (config_port_req.en |-> !busy)
      else $error("access started before ready");
   a_hold_rx: assert property (!ok |=> state_debug[0] && tuning_done == 8'h00)
      else $error("not held while receive paths unready");
   a_leave_hold: assert property (state_debug[0] && ok |=> state_debug[1])
      else $error("hold not left when ready");
   a_tune_bits: assert property (config_port_req.en && config_port_req.we
      |-> config_port_req.wdata[1:0] == 2'b11)
      else $error("coarse or fine tuning not enabled");
   a_loop_bit: assert property (config_port_req.en && config_port_req.we
      |-> config_port_req.wdata[CTRL_LOOP_BIT] == near_loopback_en[status_channel_debug[2:0]])
      else $error("loopback bit differs from user setting");
   a_ctrl_addr: assert property (config_port_req.en && config_port_req.we
      |-> config_port_req.addr == 16'(CTRL_BASE + 16'(status_channel_debug) * CHAN_STRIDE))
      else $error("control write to wrong address");
   a_stat_addr: assert property (config_port_req.en && !config_port_req.we
      |-> config_port_req.addr == 16'(STAT_BASE + 16'(status_channel_debug) * CHAN_STRIDE))
      else $error("status read from wrong address");
   a_done_halt: assert property (state_debug[5] && ok && !retune_req
      |=> state_debug[5] && $stable(tuning_done))
      else $error("finished state left without request");
   a_retune_take: assert property (state_debug[5] && ok && retune_req && channel_select < 4'h8
      |=> state_debug[1] && !tuning_done[$past(channel_select[2:0])])
      else $error("retune not taken");
   a_bad_select: assert property (state_debug[5] && ok && retune_req && channel_select > 4'h8
      |=> state_debug[5] && $stable(tuning_done))
      else $error("illegal select acted on");
   a_state_onehot: assert property ($onehot(state_debug))
      else $error("debug state not one-hot");
endmodule
bind eqt_tuning_fsm eqt_checker u_chk (.clk_sys(clk_sys), .rst(rst), .tuning_reset(tuning_reset),
   .rx_path_ready(rx_path_ready), .active_channels(active_channels), .channel_select(channel_select),
   .retune_req(retune_req), .near_loopback_en(near_loopback_en), .tuning_done(tuning_done),
   .state_debug(state_debug), .status_channel_debug(status_channel_debug),
   .config_port_req(config_port_req), .config_port_rdata(config_port_rdata),
   .config_port_ready(config_port_ready));

// >>> tb/eqt_tuning_fsm_test.sv
// Self-checking bench of the tuning machine against a port model.
// Assumes the lower four channels active after start-up and one 200 MHz clock.
`timescale 1ns/1ps
// =====
// Bench
module eqt_tuning_fsm_test;
   import eqt_pkg::*;
   logic clk_sys = 0, rst = 1, tuning_reset = 0, retune_req = 0, slow = 0, err = 0;
   logic [7:0] rx_path_ready = 8'h0F, near_loopback_en = 8'h05, tuning_done;
   logic [7:0] active_channels = 8'hFF, done_q = 8'h00, fifo_seen = 8'h00, rx_fifo_reset_in;
   logic [3:0] channel_select = 4'h0, need = 4'h1, status_channel_debug;
   logic [8:0] state_debug;
   logic [31:0] rdata;
   logic ready;
   eqt_cfg_req_s req;
   int bad_count = 0, tests_run = 0, cyc = 0;
   always #2.5 clk_sys = ~clk_sys;
   eqt_tuning_fsm DUT (.clk_sys(clk_sys), .rst(rst), .tuning_reset(tuning_reset),
      .rx_path_ready(rx_path_ready), .active_channels(active_channels), .channel_select(channel_select),
      .retune_req(retune_req), .near_loopback_en(near_loopback_en), .tuning_done(tuning_done),
      .state_debug(state_debug), .status_channel_debug(status_channel_debug),
      .config_port_req(req), .config_port_rdata(rdata), .config_port_ready(ready));
   eqt_port_model PM (.clk_sys(clk_sys), .rst(rst), .slow(slow), .err(err), .need(need),
      .req(req), .rdata(rdata), .ready(ready));
   // Receive FIFO reset pulses once per rising completion flag
   assign rx_fifo_reset_in = tuning_done & ~done_q;
   always @(posedge clk_sys) begin
      done_q    <= tuning_done;
      fifo_seen <= fifo_seen | rx_fifo_reset_in;
   end
   task automatic test_done();
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Hang guard, well above the longest run
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic to_done();
      int i;
      for (i = 0; i < 4000 && state_debug[5] !== 1'b1; i++) tick();
      chk("state", 9'h020, state_debug);
   endtask
   // Select and loopback settle a cycle before the one-cycle request
   task automatic retune(logic [3:0] sel, logic [7:0] lb);
      channel_select = sel;
      near_loopback_en = lb;
      tick();
      retune_req = 1;
      tick();
      retune_req = 0;
   endtask
   initial begin
      tick(20);
      rst = 0;
      tick(10);
      chk("hold", 9'h001, state_debug);
      active_channels = 8'h0F;
      tick();
      chk("leave", 9'h002, state_debug);
      to_done();
      chk("flags", 9'h0FF, {1'b0, tuning_done});
      tick(5);
      chk("halt", 9'h020, state_debug);
      fifo_seen = 8'h00;
      retune(4'h3, 8'h0D);
      chk("clear3", 9'h0F7, {1'b0, tuning_done});
      to_done();
      chk("set3", 9'h0FF, {1'b0, tuning_done});
      chk("fifo rst", 9'h008, {1'b0, fifo_seen});
      retune(4'h9, 8'h0D);
      chk("bad sel", 9'h020, state_debug);
      chk("bad flags", 9'h0FF, {1'b0, tuning_done});
      err = 1;
      retune(4'h5, 8'h0D);
      to_done();
      chk("err5", 9'h0DF, {1'b0, tuning_done});
      chk("dbg ch", 9'h005, {5'h0, status_channel_debug});
      err = 0;
      slow = 1;
      need = 4'h3;
      retune(4'h8, 8'h00);
      chk("all clr", 9'h000, {1'b0, tuning_done});
      to_done();
      chk("all set", 9'h0FF, {1'b0, tuning_done});
      tuning_reset = 1;
      tick();
      tuning_reset = 0;
      chk("treset", 9'h000, {1'b0, tuning_done});
      to_done();
      chk("rerun", 9'h0FF, {1'b0, tuning_done});
      // An active channel losing its receive path parks the tuner again
      rx_path_ready = 8'h07;
      tick();
      chk("drop", 9'h001, state_debug);
      chk("drop flags", 9'h000, {1'b0, tuning_done});
      rx_path_ready = 8'h0F;
      tick();
      chk("regain", 9'h002, state_debug);
      test_done();
   end
endmodule
